// ### logic/ivp_unit.sv
`timescale 1ns/10ps
`default_nettype none
module ivp_unit import ivp_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral event pulses
  input wire logic watchdog_overflow_irq,
  input wire logic sio0_done_irq,
  input wire logic sio1_done_irq,
  input wire logic uart_rx_error_irq,
  input wire logic uart_rx_done_irq,
  input wire logic sio2_done_irq,
  input wire logic uart_tx_done_irq,
  input wire logic watch_interval_irq,
  input wire logic cc0_match_irq,
  input wire logic cc1_match_irq,
  input wire logic timer8_a_match_irq,
  input wire logic timer8_b_match_irq,
  input wire logic adc_done_irq,
  // Device pins
  input wire logic [NEXT-1:0] ext_irq,
  input wire logic [7:0] port4_pin,
  // CPU core
  input wire logic cpu_ack,
  input wire logic cpu_brk,
  input wire logic cpu_reti,
  output ivp_cpu_t cpu_req,
  output logic irq
);
  // ************************************************
  // Helpers
  // ************************************************
  // Lowest set index, so order 0 wins
  function automatic logic [4:0] first_set(input logic [NSLOT-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // Vector two bytes per order above base
  function automatic logic [15:0] vec_of(input logic [4:0] idx);
    return VEC_BASE + {10'h000, idx, 1'b0};
  endfunction

  // Mapped word address
  function automatic logic reg_hit(input logic [7:0] a);
    return (a <= A_VEC) && (a[1:0] == 2'h0);
  endfunction

  // ************************************************
  // State
  // ************************************************
  logic [NSLOT-1:0] req; // Request flags
  logic [NSLOT-1:0] mask_flag; // 1 masks a slot
  logic [NSLOT-1:0] level_select_flag; // 0 is high level
  logic [NEXT-1:0] rise_en; // Rising edge select
  logic [NEXT-1:0] fall_en; // Falling edge select
  ivp_ctrl_t ctrl; // Enable, mode, in-service
  logic [NST-1:0] status; // Sticky events
  logic [NST-1:0] imask; // Interrupt output mask
  logic [15:0] last_vec; // Last accepted vector
  logic nmi_pend; // Pending watchdog NMI
  logic brk_pend; // Pending software request
  ivp_kind_t win_kind; // Kind on cpu_req
  logic [4:0] win_idx; // Slot on cpu_req
  logic [NSLOT-1:0] grp_q; // Candidate group, for checks
  logic [NEXT-1:0] ext_s1, ext_s2, ext_d; // Pin sync
  logic [7:0] p4_s1, p4_s2, p4_d; // Port 4 sync
  // Combinational terms
  logic [NEXT-1:0] ext_evt;
  logic [NSLOT-1:0] src, pend, hi, grp;
  logic [NSLOT-1:0] next_req;
  logic [NST-1:0] next_status;
  logic acc, wr, taken, take_mask, nmi_evt, p4_fall, can_mask;
  ivp_kind_t next_kind;
  logic [4:0] next_idx;
  logic [15:0] next_vec;

  // ************************************************
  // Pin synchronisers and edge detect
  // ************************************************
  // Two flops, then a third for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1 <= '0;
      ext_s2 <= '0;
      ext_d <= '0;
      p4_s1 <= '0;
      p4_s2 <= '0;
      p4_d <= '0;
    end else begin
      ext_s1 <= ext_irq;
      ext_s2 <= ext_s1;
      ext_d <= ext_s2;
      p4_s1 <= port4_pin;
      p4_s2 <= p4_s1;
      p4_d <= p4_s2;
    end
  end

  // Selected edges per pin
  for (genvar g = 0; g < NEXT; g++) begin : g_edge
    assign ext_evt[g] = (rise_en[g] & ext_s2[g] & ~ext_d[g]) |
                        (fall_en[g] & ~ext_s2[g] & ext_d[g]);
  end

  // Any port 4 pin falling
  assign p4_fall = |(p4_d & ~p4_s2);

  // ************************************************
  // Source to slot mapping
  // ************************************************
  assign nmi_evt = watchdog_overflow_irq & ~ctrl.wdt_interval;

  // One slot per default order
  always_comb begin
    src = '0;
    src[SLOT_WDT] = watchdog_overflow_irq & ctrl.wdt_interval;
    src[SLOT_EXT0 +: NEXT] = ext_evt;
    src[SLOT_SIO0] = sio0_done_irq;
    src[SLOT_SIO1] = sio1_done_irq;
    src[SLOT_RXERR] = uart_rx_error_irq;
    src[SLOT_RX] = uart_rx_done_irq | sio2_done_irq;
    src[SLOT_TX] = uart_tx_done_irq;
    src[SLOT_WATCH] = watch_interval_irq;
    src[SLOT_CC0] = cc0_match_irq;
    src[SLOT_CC1] = cc1_match_irq;
    src[SLOT_T8A] = timer8_a_match_irq;
    src[SLOT_T8B] = timer8_b_match_irq;
    src[SLOT_ADC] = adc_done_irq;
  end

  // ************************************************
  // APB strobes
  // ************************************************
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite & reg_hit(paddr);
  assign taken = cpu_ack & cpu_req.irq;
  assign take_mask = taken & (win_kind == K_MASK);

  // ************************************************
  // Arbitration
  // ************************************************
  assign pend = req & ~mask_flag;
  assign hi = pend & ~level_select_flag;
  assign grp = (|hi) ? hi : pend;
  assign can_mask = ctrl.enable & ~ctrl.in_service & (|pend);

  // NMI, then software, then maskable
  always_comb begin
    next_kind = K_NONE;
    next_idx = first_set(grp);
    next_vec = 16'h0000;
    if (nmi_pend) begin
      next_kind = K_NMI;
      next_vec = VEC_NMI;
    end else if (brk_pend) begin
      next_kind = K_BRK;
      next_vec = VEC_BRK;
    end else if (can_mask) begin
      next_kind = K_MASK;
      next_vec = vec_of(next_idx);
    end
    // Gap cycle after acceptance
    if (taken) begin
      next_kind = K_NONE;
      next_vec = 16'h0000;
    end
  end

  // Registered request to the CPU
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_req <= '0;
      win_kind <= K_NONE;
      win_idx <= 5'h00;
      grp_q <= '0;
    end else begin
      cpu_req.irq <= (next_kind != K_NONE);
      cpu_req.nmi <= (next_kind == K_NMI);
      cpu_req.vector <= next_vec;
      win_kind <= next_kind;
      win_idx <= next_idx;
      grp_q <= grp;
    end
  end

  // ************************************************
  // Request flags
  // ************************************************
  // Event set beats any clear
  always_comb begin
    next_req = (wr && paddr == A_REQ) ? pwdata[NSLOT-1:0] : req;
    if (take_mask) begin
      next_req[win_idx] = 1'b0;
    end
    next_req = next_req | src;
  end

  // Flag storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= '0;
    end else begin
      req <= next_req;
    end
  end

  // NMI and software pending, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_pend <= 1'b0;
      brk_pend <= 1'b0;
    end else begin
      nmi_pend <= nmi_evt | (nmi_pend & ~(taken & win_kind == K_NMI));
      brk_pend <= cpu_brk | (brk_pend & ~(taken & win_kind == K_BRK));
    end
  end

  // ************************************************
  // Configuration registers
  // ************************************************
  // Mask, level and edge selects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_flag <= MASK_RST;
      level_select_flag <= LEVEL_RST;
      rise_en <= '0;
      fall_en <= '0;
      imask <= '0;
    end else if (wr) begin
      case (paddr)
        A_MASK: mask_flag <= pwdata[NSLOT-1:0];
        A_LEVEL: level_select_flag <= pwdata[NSLOT-1:0];
        A_RISE: rise_en <= pwdata[NEXT-1:0];
        A_FALL: fall_en <= pwdata[NEXT-1:0];
        A_IMASK: imask <= pwdata[NST-1:0];
        default: ;
      endcase
    end
  end

  // Control word in one process; enable drops on maskable acceptance, but a CTRL write in the same cycle wins
  // In-service set by high level acceptance, which beats any clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
    end else begin
      if (wr && paddr == A_CTRL) begin
        ctrl.enable <= pwdata[0];
        ctrl.wdt_interval <= pwdata[1];
      end else if (take_mask) begin
        ctrl.enable <= 1'b0;
      end
      if (take_mask && !level_select_flag[win_idx]) begin
        ctrl.in_service <= 1'b1;
      end else if (wr && paddr == A_CTRL) begin
        ctrl.in_service <= pwdata[2];
      end else if (cpu_reti) begin
        ctrl.in_service <= 1'b0;
      end
    end
  end

  // Last accepted vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_vec <= 16'h0000;
    end else if (taken) begin
      last_vec <= cpu_req.vector;
    end
  end

  // ************************************************
  // Status and interrupt output
  // ************************************************
  // Write one to clear, event wins
  always_comb begin
    next_status = status;
    if (wr && paddr == A_STAT) begin
      next_status = status & ~pwdata[NST-1:0];
    end
    next_status[ST_P4] = next_status[ST_P4] | p4_fall;
    next_status[ST_NMI] = next_status[ST_NMI] | nmi_evt;
    next_status[ST_ACC] = next_status[ST_ACC] | take_mask;
  end

  // Status and level output flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= |(next_status & imask);
    end
  end

  // ************************************************
  // APB read side
  // ************************************************
  // Answer one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~reg_hit(paddr);
      case (paddr)
        A_REQ: prdata <= {13'h0000, req};
        A_MASK: prdata <= {13'h0000, mask_flag};
        A_LEVEL: prdata <= {13'h0000, level_select_flag};
        A_RISE: prdata <= {25'h0000000, rise_en};
        A_FALL: prdata <= {25'h0000000, fall_en};
        A_CTRL: prdata <= {29'h00000000, ctrl};
        A_STAT: prdata <= {29'h00000000, status};
        A_IMASK: prdata <= {29'h00000000, imask};
        A_VEC: prdata <= {16'h0000, last_vec};
        default: prdata <= '0;
      endcase
    end
  end

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_take;
    cpu_ack && cpu_req.irq && win_kind == K_MASK;
  endsequence

  sequence s_nmi_new;
    $rose(nmi_pend) && !cpu_ack;
  endsequence

  a_nmi_raise: assert property (
    watchdog_overflow_irq && !ctrl.wdt_interval |=> nmi_pend)
    else $error("watchdog overflow did not pend NMI");
  a_nmi_present: assert property (
    s_nmi_new |=> cpu_req.irq && cpu_req.nmi && cpu_req.vector == 16'h0004)
    else $error("NMI not presented at 0004");
  a_wdt_maskable: assert property (
    watchdog_overflow_irq && ctrl.wdt_interval |=> req[0] && !nmi_pend[*1])
    else $error("interval watchdog not in slot 0");
  a_pin_edge: assert property (
    ext_s2[0] && !ext_d[0] && rise_en[0] |=> req[1])
    else $error("pin 0 rising edge lost");
  a_shared_slot: assert property (
    sio2_done_irq |=> req[11])
    else $error("channel 2 done not in slot 11");
  a_vec_sio0: assert property (
    cpu_req.irq && win_kind == K_MASK && win_idx == 5'h08 |-> cpu_req.vector == 16'h0014)
    else $error("slot 8 vector wrong");
  a_vec_cc0: assert property (
    cpu_req.irq && win_kind == K_MASK && win_idx == 5'h0E |-> cpu_req.vector == 16'h0020)
    else $error("slot 14 vector wrong");
  a_vec_adc: assert property (
    cpu_req.irq && win_kind == K_MASK && win_idx == 5'h12 |-> cpu_req.vector == 16'h0028)
    else $error("slot 18 vector wrong");
  a_accept_gate: assert property (
    cpu_req.irq && win_kind == K_MASK |->
      grp_q[win_idx] && $past(ctrl.enable) && !$past(ctrl.in_service))
    else $error("maskable request presented while gated");
  a_default_order: assert property (
    cpu_req.irq && win_kind == K_MASK |->
      (grp_q & ((19'h00001 << win_idx) - 19'h00001)) == 19'h00000)
    else $error("lower order request was skipped");
  a_ack_clear: assert property (
    s_take |=> !cpu_req.irq && (!req[$past(win_idx)] || $past(src[win_idx])))
    else $error("accepted request flag not cleared");
  a_port4_flag: assert property (
    (|(p4_d & ~p4_s2)) |=> status[ST_P4] ##1 (status[ST_P4] || $past(wr)))
    else $error("port 4 falling edge flag not set");
endmodule
`default_nettype wire

// ### logic/ivp_pkg.sv
// Summary of operation
// - Twenty-two sources: one NMI, twenty maskable, software
// - Simultaneous maskable requests resolve by level, high first, then by default order
// - Watchdog mode overflow raises NMI, vector 0004H
// - Interval mode watchdog overflow is maskable order 0
// - Pin edges give orders 1-7, vectors 0006H-0012H
// - Channel 0 done: order 8, vector 0014H
// - Channel 1 done: order 9, vector 0016H
// - UART receive error: order 10, vector 0018H
// - UART receive and channel 2 share 001AH
// - UART transmit done: order 12, vector 001CH
// - Watch interval: order 13, vector 001EH
// - Compare 0 match: order 14, vector 0020H
// - Compare 1 match: order 15, vector 0022H
// - Port 4 falling edge sets test flag
// - 8-bit timers orders 16,17; converter 18
// - Per pin edge: rising, falling or both
// - Request, mask, level flags; in-service and enable
package ivp_pkg;
  // ************************************************
  // Sizes and slot positions
  // ************************************************
  localparam int NSLOT = 19;
  localparam int NEXT = 7;
  localparam int NST = 3;
  localparam int SLOT_WDT = 0;
  localparam int SLOT_EXT0 = 1;
  localparam int SLOT_SIO0 = 8;
  localparam int SLOT_SIO1 = 9;
  localparam int SLOT_RXERR = 10;
  localparam int SLOT_RX = 11;
  localparam int SLOT_TX = 12;
  localparam int SLOT_WATCH = 13;
  localparam int SLOT_CC0 = 14;
  localparam int SLOT_CC1 = 15;
  localparam int SLOT_T8A = 16;
  localparam int SLOT_T8B = 17;
  localparam int SLOT_ADC = 18;
  // ************************************************
  // Register byte addresses
  // ************************************************
  localparam logic [7:0] A_REQ = 8'h00;
  localparam logic [7:0] A_MASK = 8'h04;
  localparam logic [7:0] A_LEVEL = 8'h08;
  localparam logic [7:0] A_RISE = 8'h0C;
  localparam logic [7:0] A_FALL = 8'h10;
  localparam logic [7:0] A_CTRL = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam logic [7:0] A_IMASK = 8'h1C;
  localparam logic [7:0] A_VEC = 8'h20;
  // ************************************************
  // Reset values, vectors, status bits
  // ************************************************
  localparam logic [NSLOT-1:0] MASK_RST = 19'h7FFFF;
  localparam logic [NSLOT-1:0] LEVEL_RST = 19'h7FFFF;
  localparam logic [15:0] VEC_NMI = 16'h0004;
  localparam logic [15:0] VEC_BASE = 16'h0004;
  localparam logic [15:0] VEC_BRK = 16'h003E;
  localparam int ST_P4 = 0;
  localparam int ST_NMI = 1;
  localparam int ST_ACC = 2;
  // ************************************************
  // Types
  // ************************************************
  typedef enum logic [1:0] {K_NONE, K_NMI, K_BRK, K_MASK} ivp_kind_t;
  typedef struct packed {
    logic in_service;
    logic wdt_interval;
    logic enable;
  } ivp_ctrl_t;
  typedef struct packed {
    logic nmi;
    logic irq;
    logic [15:0] vector;
  } ivp_cpu_t;
endpackage

// ### verification/ivp_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module ivp_cpu_model import ivp_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request from the unit and answer speed
  input wire ivp_cpu_t cpu_req,
  input wire logic [3:0] ack_delay,
  // Acceptance pulse
  output logic cpu_ack,
  // Record of acceptances
  output logic [7:0] acc_cnt,
  output logic [15:0] acc_vec,
  output logic acc_nmi
);
  logic [3:0] wait_cnt; // Cycles waited so far

  // ************************************************
  // Core side: answer after ack_delay cycles
  // ************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (cpu_req.irq && !cpu_ack) begin
      // Request stands: count, then pulse once
      if (wait_cnt == ack_delay) begin
        cpu_ack <= 1'b1;
        wait_cnt <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end else begin
      cpu_ack <= 1'b0;
    end
  end

  // Takes the vector at the edge the unit sees the ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_cnt <= 8'h00;
      acc_vec <= 16'h0000;
      acc_nmi <= 1'b0;
    end else if (cpu_ack && cpu_req.irq) begin
      acc_cnt <= acc_cnt + 8'h01;
      acc_vec <= cpu_req.vector;
      acc_nmi <= cpu_req.nmi;
    end
  end
endmodule
`default_nettype wire

// ### verification/tb_interrupt_vector_priority_unit.sv
`timescale 1ns/10ps
`default_nettype none
module tb_interrupt_vector_priority_unit;
  import ivp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, cpu_brk, cpu_ack, irq, pready, pslverr, acc_nmi;
  logic cpu_reti; // Return from service pulse
  logic [7:0] paddr, port4_pin, acc_cnt, seen;
  logic [31:0] pwdata, prdata;
  logic [12:0] ev; // Peripheral event pulses
  logic [6:0] ext; // External pins
  logic [3:0] ack_delay;
  logic [15:0] acc_vec;
  ivp_cpu_t cpu_req;
  int mismatches = 0;
  int check_count = 0;
  int sl [13] = '{0, 8, 9, 10, 11, 11, 12, 13, 14, 15, 16, 17, 18}; // Slot of each event

  ivp_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .watchdog_overflow_irq(ev[0]), .sio0_done_irq(ev[1]),
    .sio1_done_irq(ev[2]), .uart_rx_error_irq(ev[3]), .uart_rx_done_irq(ev[4]),
    .sio2_done_irq(ev[5]), .uart_tx_done_irq(ev[6]), .watch_interval_irq(ev[7]),
    .cc0_match_irq(ev[8]), .cc1_match_irq(ev[9]), .timer8_a_match_irq(ev[10]),
    .timer8_b_match_irq(ev[11]), .adc_done_irq(ev[12]), .ext_irq(ext),
    .port4_pin(port4_pin), .cpu_ack(cpu_ack), .cpu_brk(cpu_brk), .cpu_reti(cpu_reti),
    .cpu_req(cpu_req), .irq(irq));
  ivp_cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .cpu_req(cpu_req),
    .ack_delay(ack_delay), .cpu_ack(cpu_ack), .acc_cnt(acc_cnt), .acc_vec(acc_vec),
    .acc_nmi(acc_nmi));

  // ************************************************
  // Common tasks
  // ************************************************
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic hang();
    mismatches++;
    $display("Error at %0t: wait ran out", $time);
    give_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) hang();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask
  task automatic pulse(input logic [12:0] m);
    @(posedge pclk) ev <= m;
    @(posedge pclk) ev <= '0;
  endtask
  task automatic pin(input int k, input logic v);
    @(posedge pclk) ext[k] <= v;
  endtask
  // Waits for one acceptance and compares its vector
  task automatic svc(input logic [15:0] v);
    int n;
    for (n = 0; n < 60; n++) begin
      @(posedge pclk);
      if (acc_cnt !== seen) break;
    end
    if (n == 60) hang();
    seen = acc_cnt;
    chk({16'h0, acc_vec}, {16'h0, v});
  endtask
  task automatic none();
    repeat (12) @(posedge pclk);
    chk({24'h0, acc_cnt}, {24'h0, seen});
  endtask

  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd(A_MASK, 32'h7FFFF);
    rd(A_LEVEL, 32'h7FFFF);
    rd(A_CTRL, 32'h0);
    rd(A_FALL, 32'h0);
    apb(1'b0, 8'h24, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
  endtask
  // Every event source alone, answered at varied speed
  task automatic t_each();
    for (int i = 0; i < 13; i++) begin
      wr(A_MASK, ~(32'h1 << sl[i]));
      wr(A_CTRL, (i == 0) ? 32'h3 : 32'h1);
      ack_delay <= 4'(i % 4);
      pulse(13'h1 << i);
      svc(16'h0004 + 16'(2 * sl[i]));
      rd(A_REQ, 32'h0);
    end
  endtask
  task automatic t_order();
    wr(A_MASK, 32'h0);
    wr(A_CTRL, 32'h1);
    pulse(13'h1004);
    svc(16'h0016);
    rd(A_REQ, 32'h40000);
    wr(A_CTRL, 32'h1);
    svc(16'h0028);
  endtask
  task automatic t_gate();
    wr(A_CTRL, 32'h0);
    pulse(13'h0100);
    none();
    rd(A_REQ, 32'h4000);
    wr(A_MASK, 32'h7FFFF);
    wr(A_CTRL, 32'h1);
    none();
    wr(A_MASK, 32'h0);
    svc(16'h0020);
  endtask
  // High level acceptance blocks all maskable until return
  task automatic t_isr();
    wr(A_LEVEL, 32'h7BFFF);
    wr(A_MASK, 32'h0);
    wr(A_CTRL, 32'h1);
    pulse(13'h0100);
    svc(16'h0020);
    rd(A_CTRL, 32'h4);
    wr(A_CTRL, 32'h5);
    pulse(13'h0002);
    none();
    @(posedge pclk) cpu_reti <= 1'b1;
    @(posedge pclk) cpu_reti <= 1'b0;
    svc(16'h0014);
    wr(A_LEVEL, 32'h7FFFF);
  endtask
  task automatic t_nmi();
    wr(A_CTRL, 32'h0);
    wr(A_MASK, 32'h7FFFF);
    wr(A_STAT, 32'h7);
    pulse(13'h1);
    svc(16'h0004);
    chk({31'h0, acc_nmi}, 32'h1);
    rd(A_STAT, 32'h2);
  endtask
  task automatic t_pins();
    wr(A_MASK, 32'h0);
    for (int k = 0; k < 7; k++) begin
      wr(A_RISE, 32'h1 << k);
      wr(A_FALL, 32'h0);
      wr(A_CTRL, 32'h1);
      pin(k, 1'b1);
      svc(16'h0006 + 16'(2 * k));
      wr(A_CTRL, 32'h1);
      pin(k, 1'b0);
      none();
      wr(A_RISE, 32'h0);
      wr(A_FALL, 32'h1 << k);
      pin(k, 1'b1);
      none();
      pin(k, 1'b0);
      svc(16'h0006 + 16'(2 * k));
    end
    wr(A_RISE, 32'h1);
    wr(A_FALL, 32'h1);
    wr(A_CTRL, 32'h1);
    pin(0, 1'b1);
    svc(16'h0006);
    wr(A_CTRL, 32'h1);
    pin(0, 1'b0);
    svc(16'h0006);
  endtask
  // Port 4 fall: masked first, then unmasked, then cleared
  task automatic t_port4();
    wr(A_STAT, 32'h7);
    @(posedge pclk) port4_pin <= 8'hF7;
    repeat (8) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rd(A_STAT, 32'h1);
    wr(A_IMASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(A_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    port4_pin <= 8'hFF;
  endtask
  task automatic t_brk();
    @(posedge pclk) cpu_brk <= 1'b1;
    @(posedge pclk) cpu_brk <= 1'b0;
    svc(16'h003E);
  endtask

  // ************************************************
  // Clock and main sequence
  // ************************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, cpu_brk, cpu_reti} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ev = '0;
    ext = '0;
    port4_pin = 8'hFF;
    ack_delay = 4'h0;
    seen = 8'h00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset();
    t_each();
    t_order();
    t_gate();
    t_isr();
    t_nmi();
    t_pins();
    t_port4();
    t_brk();
    give_verdict();
  end
endmodule
`default_nettype wire
